// ===== inc/instruction_sampling_defines.vh
// register offsets, field positions and reset values for the instruction sampling monitor
`ifndef INSTRUCTION_SAMPLING_DEFINES_VH
`define INSTRUCTION_SAMPLING_DEFINES_VH
// wishbone word byte offsets
`define REG_FETCH_CTL      8'h00
`define REG_FETCH_FLAGS    8'h04
`define REG_FETCH_ADDR     8'h08
`define REG_OP_CTL         8'h0c
`define REG_OP_RESULT      8'h10
`define REG_OP_MEM_RESULT  8'h14
`define REG_OP_PARENT_ADDR 8'h18
`define REG_OP_DROP_COUNT  8'h1c
`define REG_FETCH_PHYS     8'h20
// control register fields
`define CTL_MAX_LSB    0
`define CTL_ENABLE_BIT 16
`define CTL_VALID_BIT  17
`define CTL_RAND_BIT   18
`define CTL_CYCLE_BIT  19
// fetch flag fields
`define FF_L1_MISS   0
`define FF_L2_MISS   1
`define FF_PHYS_VAL  2
`define FF_IC_MISS   3
`define FF_COMPLETED 4
`define FF_LAT_LSB   16
// op result fields
`define OR_BRANCH    0
`define OR_RETURN    1
`define OR_RESYNC    2
`define OR_T2R_LSB   16
`define OM_LOAD      0
`define OM_STORE     1
`define OM_C2R_LSB   16
// reset values
`define LFSR_SEED    7'h5a
`define MAX_RESET    16'h0000
`endif

// ===== verilog/instruction_sampling_monitor.v
// instruction fetch and op sampling monitor with a classic wishbone register slave
`timescale 1ns/1ps
`include "instruction_sampling_defines.vh"

module instruction_sampling_monitor #(
  parameter CNT_W  = 20,
  parameter ADDR_W = 48,
  parameter LAT_W  = 16
) (
  input  wire              clk,
  input  wire              rst,
  // wishbone slave
  input  wire              wbCyc,
  input  wire              wbStb,
  input  wire              wbWe,
  input  wire [7:0]        wbAdr,
  input  wire [3:0]        wbSel,
  input  wire [31:0]       wbDatW,
  output reg  [31:0]       wbDatR,
  output reg               wbAck,
  // fetch pipeline events
  input  wire              fetchStart,
  input  wire [ADDR_W-1:0] fetchVirtAddr,
  input  wire              fetchL1TlbMiss,
  input  wire              fetchL2TlbMiss,
  input  wire              fetchXlateDone,
  input  wire [ADDR_W-1:0] fetchPhysAddr,
  input  wire [1:0]        fetchPageSize,
  input  wire              fetchIcLookup,
  input  wire              fetchIcMiss,
  input  wire              fetchDelivered,
  input  wire              fetchAbort,
  // op pipeline events
  input  wire              opDecodeExit,
  input  wire              opDecodeStall,
  input  wire [ADDR_W-1:0] opParentAddr,
  input  wire              opIsBranch,
  input  wire              opIsReturn,
  input  wire              opIsResync,
  input  wire              opIsLoad,
  input  wire              opIsStore,
  input  wire              tagOpComplete,
  input  wire              tagOpRetire,
  input  wire              tagOpFlush,
  // outputs
  output wire              fetchTagActive,
  output wire              opTagActive,
  output reg               fetchIrq,
  output reg               opIrq,
  output reg               dropEvent
);

  // saturating increment used by the latency counters
  // a latency that outgrows the field sticks at all ones rather than wrapping,
  // so software can tell an overflowed sample from a short one
  function [LAT_W-1:0] satInc;
    input [LAT_W-1:0] v;
    begin
      satInc = (&v) ? v : v + {{(LAT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // fetch control and state
  reg [15:0]        fetchMax_q;     // software period, upper 16 bits
  reg               fetchEn_q;      // fetch sampling enable
  reg               fetchValid_q;   // sample ready for software
  reg               fetchRand_q;    // randomise low counter bits
  reg [CNT_W-1:0]   fetchCnt_q;     // completed fetch count
  reg               fetchArm_q;     // next attempted fetch gets tag
  reg               fetchTag_q;     // tagged fetch in progress
  reg               fL1_q;          // first-attempt l1 itlb miss
  reg               fL2_q;          // first-attempt l2 itlb miss
  reg               fPhysVal_q;     // phys address and page size valid
  reg               fIcMiss_q;      // first-attempt icache miss
  reg               fComp_q;        // bytes reached decoders
  reg               fXlSeen_q;      // translation outcome captured
  reg               fIcSeen_q;      // icache outcome captured
  reg [LAT_W-1:0]   fLat_q;         // fetch latency counter
  reg [ADDR_W-1:0]  fVirt_q;        // tagged virtual fetch address
  reg [ADDR_W-1:0]  fPhys_q;        // tagged physical fetch address
  reg [1:0]         fPage_q;        // page size
  // op control and state
  reg [15:0]        opMax_q;        // software period, upper 16 bits
  reg               opEn_q;         // op sampling enable
  reg               opValid_q;      // sample ready for software
  reg               opCycle_q;      // cycle-based mode
  reg [CNT_W-1:0]   opCnt_q;        // current cycle count
  reg               opArm_q;        // next decoded op gets tag
  reg               opTag_q;        // tagged op in flight
  reg               opDone_q;       // tagged op has completed
  reg               oBr_q;          // retired branch
  reg               oRet_q;         // return op
  reg               oRsy_q;         // resync op
  reg               oLd_q;          // load op
  reg               oSt_q;          // store op
  reg [ADDR_W-1:0]  oRip_q;         // parent instruction address
  reg [LAT_W-1:0]   oT2r_q;         // tag-to-retire cycles
  reg [LAT_W-1:0]   oC2r_q;         // complete-to-retire cycles
  reg [31:0]        dropCnt_q;      // dropped samples
  reg [6:0]         lfsr_q;         // 7-bit maximal period lfsr

  wire [CNT_W-1:0] fetchMaxFull = {fetchMax_q, 4'h0};
  wire [CNT_W-1:0] opMaxFull    = {opMax_q, 4'h0};
  wire             wbReq        = wbCyc & wbStb & ~wbAck;
  wire             wbWr         = wbReq & wbWe & wbSel[0];
  wire             wrFetchCtl   = wbWr & (wbAdr == `REG_FETCH_CTL);
  wire             wrOpCtl      = wbWr & (wbAdr == `REG_OP_CTL);

  assign fetchTagActive = fetchTag_q;
  assign opTagActive    = opTag_q;

  // lfsr runs every cycle, x^7+x^6+1
  // it free-runs so that the reload value after a flush does not depend on
  // when software last touched the control registers
  // the seed is non-zero; an all-zero state would lock the register
  always @(posedge clk) begin
    if (rst) begin
      lfsr_q <= `LFSR_SEED;
    end else begin
      lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
    end
  end

  // fetch sampling: select, track first attempts, latency, report
  // flow: count delivered fetches while idle, arm at the period, tag the next
  // attempted fetch, then record the first translation and first icache
  // outcome only; later retries of the same fetch do not touch the flags
  // the sample stays frozen while valid is set, until software clears valid
  // statements lower in this process win over the control register write,
  // so a sample that ends in the write cycle still sets valid
  always @(posedge clk) begin
    if (rst) begin
      fetchMax_q   <= `MAX_RESET;
      fetchEn_q    <= 1'b0;
      fetchValid_q <= 1'b0;
      fetchRand_q  <= 1'b0;
      fetchCnt_q   <= {CNT_W{1'b0}};
      fetchArm_q   <= 1'b0;
      fetchTag_q   <= 1'b0;
      fL1_q        <= 1'b0;
      fL2_q        <= 1'b0;
      fPhysVal_q   <= 1'b0;
      fIcMiss_q    <= 1'b0;
      fComp_q      <= 1'b0;
      fXlSeen_q    <= 1'b0;
      fIcSeen_q    <= 1'b0;
      fLat_q       <= {LAT_W{1'b0}};
      fVirt_q      <= {ADDR_W{1'b0}};
      fPhys_q      <= {ADDR_W{1'b0}};
      fPage_q      <= 2'b00;
      fetchIrq     <= 1'b0;
    end else begin
      fetchIrq <= 1'b0;
      if (wrFetchCtl) begin
        // software load; low four bits forced to zero by the concatenation above
        fetchMax_q   <= wbDatW[`CTL_MAX_LSB+15:`CTL_MAX_LSB];
        fetchEn_q    <= wbDatW[`CTL_ENABLE_BIT];
        fetchRand_q  <= wbDatW[`CTL_RAND_BIT];
        if (!wbDatW[`CTL_VALID_BIT]) begin
          fetchValid_q <= 1'b0;
          fetchCnt_q   <= {CNT_W{1'b0}};
        end
      end
      // count completed fetches while idle
      if (fetchEn_q && !fetchValid_q && !fetchTag_q && !fetchArm_q && fetchDelivered) begin
        if (fetchCnt_q + 1'b1 >= fetchMaxFull) begin
          fetchArm_q <= 1'b1;
          fetchCnt_q <= fetchRand_q ? {{(CNT_W-4){1'b0}}, lfsr_q[3:0]} : {CNT_W{1'b0}};
        end else begin
          fetchCnt_q <= fetchCnt_q + 1'b1;
        end
      end
      // next attempted fetch becomes the tagged one, flags start clear
      if (fetchArm_q && fetchStart) begin
        fetchArm_q <= 1'b0;
        fetchTag_q <= 1'b1;
        fVirt_q    <= fetchVirtAddr;
        fL1_q      <= 1'b0;
        fL2_q      <= 1'b0;
        fPhysVal_q <= 1'b0;
        fIcMiss_q  <= 1'b0;
        fComp_q    <= 1'b0;
        fXlSeen_q  <= 1'b0;
        fIcSeen_q  <= 1'b0;
        fLat_q     <= {LAT_W{1'b0}};
      end
      if (fetchTag_q) begin
        fLat_q <= satInc(fLat_q);
        // first translation attempt only
        if (fetchXlateDone && !fXlSeen_q) begin
          fXlSeen_q  <= 1'b1;
          fL1_q      <= fetchL1TlbMiss;
          fL2_q      <= fetchL1TlbMiss & fetchL2TlbMiss;
          fPhysVal_q <= 1'b1;
          fPhys_q    <= fetchPhysAddr;
          fPage_q    <= fetchPageSize;
        end
        // first icache attempt only, after translation
        if (fetchIcLookup && fXlSeen_q && !fIcSeen_q) begin
          fIcSeen_q <= 1'b1;
          fIcMiss_q <= fetchIcMiss;
        end
        if (fetchDelivered && fIcSeen_q) begin
          fComp_q      <= 1'b1;
          fetchTag_q   <= 1'b0;
          fetchValid_q <= 1'b1;
          fetchIrq     <= 1'b1;
        end else if (fetchAbort) begin
          fetchTag_q   <= 1'b0;
          fetchValid_q <= 1'b1;
          fetchIrq     <= 1'b1;
          // aborted with valid address: icache fill was under way
          if (fXlSeen_q) begin
            fIcMiss_q <= 1'b1;
          end else begin
            // a translation that lands in the abort cycle is not reported:
            // address valid without a fill miss would be an illegal combination
            fL1_q      <= fetchL1TlbMiss & ~fetchXlateDone;  // itlb reload interrupted
            fL2_q      <= 1'b0;
            fPhysVal_q <= 1'b0;
            fIcMiss_q  <= 1'b0;
          end
        end
      end
    end
  end

  // op sampling: cycle count, tag, track to retire or flush
  // flow: count every cycle while idle, arm at the period, tag the next op
  // leaving decode, then run tag-to-retire, and complete-to-retire once completed, until retire or flush
  // a flush wins over a retire in the same cycle: the op never retired
  // only one op is ever in flight, so counting pauses while armed or tagged
  // a reload value above the period arms on the very next cycle
  always @(posedge clk) begin
    if (rst) begin
      opMax_q   <= `MAX_RESET;
      opEn_q    <= 1'b0;
      opValid_q <= 1'b0;
      opCycle_q <= 1'b0;
      opCnt_q   <= {CNT_W{1'b0}};
      opArm_q   <= 1'b0;
      opTag_q   <= 1'b0;
      opDone_q  <= 1'b0;
      oBr_q     <= 1'b0;
      oRet_q    <= 1'b0;
      oRsy_q    <= 1'b0;
      oLd_q     <= 1'b0;
      oSt_q     <= 1'b0;
      oRip_q    <= {ADDR_W{1'b0}};
      oT2r_q    <= {LAT_W{1'b0}};
      oC2r_q    <= {LAT_W{1'b0}};
      dropCnt_q <= 32'h00000000;
      opIrq     <= 1'b0;
      dropEvent <= 1'b0;
    end else begin
      opIrq     <= 1'b0;
      dropEvent <= 1'b0;
      if (wrOpCtl) begin
        opMax_q   <= wbDatW[`CTL_MAX_LSB+15:`CTL_MAX_LSB];
        opEn_q    <= wbDatW[`CTL_ENABLE_BIT];
        opCycle_q <= wbDatW[`CTL_CYCLE_BIT];
        if (!wbDatW[`CTL_VALID_BIT]) begin
          opValid_q <= 1'b0;
          opCnt_q   <= {CNT_W{1'b0}};
        end
      end
      // count every cycle until maximum, then arm
      if (opEn_q && !opValid_q && !opTag_q && !opArm_q) begin
        if (opCnt_q >= opMaxFull) begin
          opArm_q <= 1'b1;
          opCnt_q <= {CNT_W{1'b0}};
          oT2r_q  <= {LAT_W{1'b0}};
        end else begin
          opCnt_q <= opCnt_q + 1'b1;
        end
      end
      // cycle mode: decode stalls while armed go into tag-to-retire
      if (opArm_q && opCycle_q && opDecodeStall) begin
        oT2r_q <= satInc(oT2r_q);
      end
      // next op leaving decode is tagged
      if (opArm_q && opDecodeExit) begin
        opArm_q  <= 1'b0;
        opTag_q  <= 1'b1;
        opDone_q <= 1'b0;
        oRip_q   <= opParentAddr;
        oBr_q    <= opIsBranch;
        oRet_q   <= opIsBranch & opIsReturn;
        oRsy_q   <= opIsResync;
        oLd_q    <= opIsLoad;
        oSt_q    <= opIsStore;
        oC2r_q   <= {LAT_W{1'b0}};
        if (!opCycle_q) begin
          oT2r_q <= {LAT_W{1'b0}};
        end
      end
      if (opTag_q) begin
        oT2r_q <= satInc(oT2r_q);
        if (opDone_q) begin
          oC2r_q <= satInc(oC2r_q);
        end
        if (tagOpComplete) begin
          opDone_q <= 1'b1;
        end
        if (tagOpFlush) begin
          // discard sample, count drop, reseed count
          opTag_q   <= 1'b0;
          dropEvent <= 1'b1;
          dropCnt_q <= dropCnt_q + 32'h00000001;
          opCnt_q   <= {{(CNT_W-7){1'b0}}, lfsr_q};
        end else if (tagOpRetire) begin
          opTag_q   <= 1'b0;
          opValid_q <= 1'b1;
          opIrq     <= 1'b1;
        end
      end
    end
  end

  // wishbone read mux and single-cycle ack
  // ack follows one cycle after the request edge and drops on its own, since
  // a request is only taken while ack is low
  // read data is captured with the request and holds until the next read
  // fields wider than 32 bits report their low word only
  always @(posedge clk) begin
    if (rst) begin
      wbAck  <= 1'b0;
      wbDatR <= 32'h00000000;
    end else begin
      wbAck <= wbReq;
      if (wbReq && !wbWe) begin
        case (wbAdr)
          `REG_FETCH_CTL:      wbDatR <= {12'h000, 1'b0, fetchRand_q, fetchValid_q, fetchEn_q, fetchMax_q};
          `REG_FETCH_FLAGS:    wbDatR <= {fLat_q, 9'h000, fPage_q, fComp_q, fIcMiss_q, fPhysVal_q, fL2_q, fL1_q};
          `REG_FETCH_ADDR:     wbDatR <= fVirt_q[31:0];
          `REG_FETCH_PHYS:     wbDatR <= fPhys_q[31:0];
          `REG_OP_CTL:         wbDatR <= {12'h000, opCycle_q, 1'b0, opValid_q, opEn_q, opMax_q};
          `REG_OP_RESULT:      wbDatR <= {oT2r_q, 13'h0000, oRsy_q, oRet_q, oBr_q};
          `REG_OP_MEM_RESULT:  wbDatR <= {oC2r_q, 14'h0000, oSt_q, oLd_q};
          `REG_OP_PARENT_ADDR: wbDatR <= oRip_q[31:0];
          `REG_OP_DROP_COUNT:  wbDatR <= dropCnt_q;
          default:             wbDatR <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// ===== test/sampling_checker.sv
// port assertions for the sampling monitor
`timescale 1ns/1ps
module sampling_checker (
  input wire clk,
  input wire rst,
  input wire wbCyc,
  input wire wbStb,
  input wire wbAck,
  input wire fetchDelivered,
  input wire fetchAbort,
  input wire fetchTagActive,
  input wire fetchIrq,
  input wire tagOpRetire,
  input wire tagOpFlush,
  input wire opTagActive,
  input wire opIrq,
  input wire dropEvent
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_ack_single: assert property (wbAck |=> !wbAck) else $error("ack held too long");
  a_ack_answer: assert property (wbCyc && wbStb && !wbAck |=> wbAck) else $error("request not answered");
  a_retire_irq: assert property (opTagActive && tagOpRetire && !tagOpFlush |=> opIrq && !dropEvent)
    else $error("retired op gave no interrupt");
  a_flush_drop: assert property (opTagActive && tagOpFlush |=> dropEvent && !opIrq)
    else $error("flushed op not dropped");
  a_irq_cause: assert property (opIrq |-> $past(opTagActive) && $past(tagOpRetire))
    else $error("op interrupt without retire");
  a_tag_hold: assert property (opTagActive && !tagOpRetire && !tagOpFlush |=> opTagActive)
    else $error("tag lost in flight");
  a_tag_clear: assert property (opTagActive && (tagOpRetire || tagOpFlush) |=> !opTagActive)
    else $error("tag kept after end");
  a_fetch_cause: assert property (fetchIrq |-> $past(fetchTagActive) && ($past(fetchDelivered) || $past(fetchAbort)))
    else $error("fetch interrupt without end");
  a_abort_irq: assert property (fetchTagActive && fetchAbort |=> fetchIrq)
    else $error("aborted fetch gave no interrupt");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> !(opIrq || fetchIrq || dropEvent || wbAck))
    else $error("output active after reset");
endmodule

bind instruction_sampling_monitor sampling_checker sampling_checker_inst (.*);

// ===== test/pipe_model.sv
// behavioural fetch and op pipeline that feeds the monitor
`timescale 1ns/1ps
module pipe_model (
  input  wire        clk,
  input  wire        opTagActive,
  output reg         fetchL1TlbMiss,
  output reg         fetchL2TlbMiss,
  output reg  [47:0] fetchPhysAddr,
  output reg         fetchIcMiss,
  output wire        fetchStart,
  output wire        fetchXlateDone,
  output wire        fetchIcLookup,
  output wire        fetchDelivered,
  output wire        fetchAbort,
  output reg  [47:0] opParentAddr,
  output reg         opIsBranch,
  output reg         opIsReturn,
  output reg         opIsResync,
  output reg         opIsLoad,
  output reg         opIsStore,
  output wire        opDecodeExit,
  output wire        tagOpComplete,
  output wire        tagOpRetire,
  output wire        tagOpFlush
);
  reg [4:0] fp;     // abort, delivered, lookup, translated, start
  reg [3:0] op;     // flush, retire, complete, decode exit
  int       steps;  // edges stepped by the fetch driver
  assign {fetchAbort, fetchDelivered, fetchIcLookup, fetchXlateDone, fetchStart} = fp;
  assign {tagOpFlush, tagOpRetire, tagOpComplete, opDecodeExit} = op;
  // quiet at time zero
  initial begin
    fp = 5'h00;
    op = 4'h0;
    steps = 0;
    {fetchL1TlbMiss, fetchL2TlbMiss, fetchIcMiss} = 3'h0;
    {opIsBranch, opIsReturn, opIsResync, opIsLoad, opIsStore} = 5'h00;
    fetchPhysAddr = 48'h0;
    opParentAddr = 48'h0;
  end
  // present one fetch pulse pattern after an edge
  task fs(input logic [4:0] v);
    @(posedge clk);
    fp <= v;
    steps++;
  endtask
  // one fetch: st 0 killed early, 2 aborted in fill, 3 delivered
  task fetch(input logic l1, input logic l2, input logic ic, input int st, output int lat);
    fs(5'h01);
    fetchPhysAddr <= 48'h0000_8000;
    fetchL1TlbMiss <= l1;
    fetchL2TlbMiss <= l2;
    fetchIcMiss <= ic;
    lat = steps;
    if (st != 0) begin
      fs(5'h02);
      fs(5'h04);
      if (ic && st == 3) begin
        fs(5'h04);
        fetchIcMiss <= 1'b0;
      end
    end
    fs(st == 3 ? 5'h08 : 5'h10);
    lat = steps - lat;
    fs(5'h00);
    fetchPhysAddr <= ~48'h0000_8000;
  endtask
  // decode exits of one instruction until one is tagged
  task opTag(input logic [4:0] kind, output int n);
    {opIsStore, opIsLoad, opIsResync, opIsReturn, opIsBranch} <= kind;
    opParentAddr <= 48'h0000_7000;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      op <= {3'h0, !opTagActive};
    end while (opTagActive !== 1'b1 && n < 400);
  endtask
  // complete after c edges, then retire or flush after r more
  task opFin(input int c, input int r, input logic fl);
    repeat (c) @(posedge clk);
    op <= 4'h2;
    @(posedge clk);
    op <= 4'h0;
    repeat (r) @(posedge clk);
    op <= fl ? 4'h8 : 4'h4;
    @(posedge clk);
    op <= 4'h0;
    opParentAddr <= ~48'h0000_7000;
  endtask
endmodule

// ===== test/tb.sv
// self-checking bench for the sampling monitor
`timescale 1ns/1ps
module tb;
  reg          clk, rst, wbCyc, wbStb, wbWe, opDecodeStall;
  reg  [7:0]   wbAdr;
  reg  [3:0]   wbSel;
  reg  [31:0]  wbDatW;
  reg  [47:0]  fetchVirtAddr;
  reg  [1:0]   fetchPageSize;
  wire [31:0]  wbDatR;
  wire         wbAck, fetchTagActive, opTagActive, fetchIrq, opIrq, dropEvent;
  wire         fetchStart, fetchL1TlbMiss, fetchL2TlbMiss, fetchXlateDone, fetchIcLookup, fetchIcMiss;
  wire         fetchDelivered, fetchAbort, opDecodeExit, opIsBranch, opIsReturn, opIsResync;
  wire         opIsLoad, opIsStore, tagOpComplete, tagOpRetire, tagOpFlush;
  wire [47:0]  fetchPhysAddr, opParentAddr;
  wire [2:0]   evts = {dropEvent, opIrq, fetchIrq};  // events by index
  logic [31:0] q;                                   // last read data
  int          n;                                   // cycles waited for a tag
  int          bad_count = 0;
  int          checks = 0;

  instruction_sampling_monitor instruction_sampling_monitor_inst (.*);
  pipe_model pipe_model_inst (.*);

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // exact compare
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // compare within a tolerance
  task near(input string nm, input int e, input int tol, input logic [31:0] s);
    checks++;
    if ((s + tol >= e && s <= e + tol) !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, s);
    end
  endtask
  // one classic wishbone cycle, read data left in q
  task xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatW <= d;
    do begin
      @(posedge clk);
      t++;
    end while (wbAck !== 1'b1 && t < 50);
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
    if (t >= 50) chk("wbAck", 32'h1, 32'h0);
  endtask
  // wait for a one-cycle event
  task waitEv(input int w);
    int t;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (evts[w] !== 1'b1 && t < 200);
    chk("event", 32'h1, {31'h0, evts[w]});
  endtask
  // reset values, readback, unmapped and read-only places
  task tRegs;
    xfer(1'b0, 8'h0c, 32'h0);
    chk("opCtl", 32'h0, q);
    xfer(1'b1, 8'h0c, 32'h0000_ffff);
    xfer(1'b0, 8'h0c, 32'h0);
    chk("opCtl", 32'h0000_ffff, q);
    xfer(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, q);
    xfer(1'b1, 8'h04, 32'hffff_ffff);
    xfer(1'b0, 8'h04, 32'h0);
    chk("fetchFlags", 32'h0, q);
    $display("registers done");
  endtask
  // op samples of several kinds, retired
  task tOpSample;
    logic [4:0] kinds [3];
    kinds = '{5'h1b, 5'h04, 5'h00};
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, 8'h0c, 32'h0001_0001);
      pipe_model_inst.opTag(kinds[i], n);
      near("tagWait", 16, 3, n);
      pipe_model_inst.opFin(3, 5, 1'b0);
      waitEv(1);
      xfer(1'b0, 8'h10, 32'h0);
      chk("opKind", {29'h0, kinds[i][2:0]}, {29'h0, q[2:0]});
      near("tagToRetire", 11, 1, {16'h0, q[31:16]});
      xfer(1'b0, 8'h14, 32'h0);
      chk("memKind", {30'h0, kinds[i][4:3]}, {30'h0, q[1:0]});
      near("compToRetire", 6, 1, {16'h0, q[31:16]});
      xfer(1'b0, 8'h18, 32'h0);
      chk("parentAddr", 32'h0000_7000, q);
    end
    $display("op sample done");
  endtask
  // flushed op is dropped, counted and sampling restarts
  task tFlush;
    xfer(1'b1, 8'h0c, 32'h0001_0008);
    pipe_model_inst.opTag(5'h08, n);
    pipe_model_inst.opFin(2, 3, 1'b1);
    waitEv(2);
    xfer(1'b0, 8'h1c, 32'h0);
    chk("dropCount", 32'h1, q);
    pipe_model_inst.opTag(5'h08, n);
    near("retagWait", 67, 66, n);
    pipe_model_inst.opFin(1, 1, 1'b0);
    waitEv(1);
    $display("flush done");
  endtask
  // cycle mode adds the decode stall cycle while armed to tag-to-retire
  task tCycle;
    xfer(1'b1, 8'h0c, 32'h0009_0001);
    opDecodeStall <= 1'b1;
    pipe_model_inst.opTag(5'h00, n);
    opDecodeStall <= 1'b0;
    pipe_model_inst.opFin(3, 5, 1'b0);
    waitEv(1);
    xfer(1'b0, 8'h10, 32'h0);
    near("stallToRetire", 12, 0, {16'h0, q[31:16]});
    $display("cycle mode done");
  endtask
  // fetch outcomes: {flags, l1, l2, icmiss, stage}
  task tFetch;
    logic [9:0] fc [6];
    int lat;
    fc = '{10'h000, 10'h186, 10'h283, 10'h387, 10'h2b3, 10'h1fe};
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, 8'h00, 32'h0001_0000);
      pipe_model_inst.fetch(1'b0, 1'b0, 1'b0, 3, lat);
      pipe_model_inst.fetch(fc[i][4], fc[i][3], fc[i][2], fc[i][1:0], lat);
      waitEv(0);
      xfer(1'b0, 8'h04, 32'h0);
      chk("fetchFlags", {27'h0, fc[i][9:5]}, {27'h0, q[4:0]});
      near("fetchLat", lat, 1, {16'h0, q[31:16]});
      if (fc[i][7]) begin
        xfer(1'b0, 8'h20, 32'h0);
        chk("physAddr", 32'h0000_8000, q);
      end
    end
    $display("fetch done");
  endtask
  // verdict and end of run
  task end_sim;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial begin
    rst = 1'b1;
    {wbCyc, wbStb, wbWe, opDecodeStall} = 4'h0;
    wbAdr = 8'h00;
    wbSel = 4'hf;
    wbDatW = 32'h0;
    fetchVirtAddr = 48'h0000_4000;
    fetchPageSize = 2'h1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    tRegs();
    tOpSample();
    tFlush();
    tCycle();
    tFetch();
    end_sim();
  end
  // hang guard
  initial begin
    #100000;
    bad_count++;
    end_sim();
  end
endmodule
